// ===== logic/lcell_defines.vh
// Summary of operation
// (RULE_01) cell mode fixed by configuration, not signals
// (RULE_02) small table: two inputs, one output
// (RULE_03) small table holds four truth bits
// (RULE_04) large table: three inputs, one output
// (RULE_05) large table holds eight truth bits
// (RULE_06) small sequential: data and clock inputs
// (RULE_07) clock invert select: 0 plain, 1 inverted
// (RULE_08) plain-clock flop captures on rising edge
// (RULE_09) inverted-clock flop captures on falling edge
// (RULE_10) plain-clock latch transparent while clock low
// (RULE_11) inverted-clock latch transparent while clock high
// (RULE_12) output drives stored value or complement
// (RULE_13) storage starts from configured initial state
// (RULE_14) large sequential: data, clock, active-low control
// (RULE_15) large cell picks clear or preset
// (RULE_16) clear low forces stored value zero
// (RULE_17) preset low forces stored value one
// (RULE_18) unused control input tied high outside
// (RULE_19) clear or preset overrides clock and data
`ifndef LCELL_DEFINES_VH
`define LCELL_DEFINES_VH

// register byte offsets
`define LCELL_OFS_CFG_SMALL 12'h000
`define LCELL_OFS_CFG_LARGE 12'h004
`define LCELL_OFS_STATUS 12'h008
`define LCELL_OFS_COUNT 12'h00c

// configuration word field positions
`define LCELL_F_TRUTH_LO 0
`define LCELL_F_TRUTH_HI 7
`define LCELL_F_SEQ 8
`define LCELL_F_LATCH 9
`define LCELL_F_CLK_INV 10
`define LCELL_F_OUT_INV 11
`define LCELL_F_INIT 12
`define LCELL_F_PRESET 13
`define LCELL_CFG_W 14

// reset values
`define LCELL_CFG_RST 14'h0000
`define LCELL_CNT_RST 16'h0000

// status word field positions
`define LCELL_S_SMALL_IN 0
`define LCELL_S_LARGE_IN 4
`define LCELL_S_SMALL_OUT 8
`define LCELL_S_LARGE_OUT 9
`define LCELL_S_SMALL_ST 10
`define LCELL_S_LARGE_ST 11

// ahb encodings
`define LCELL_HTRANS_NONSEQ 2'h2
`define LCELL_HRESP_OKAY 1'h0

`endif

// ===== logic/lcell_slice.v
`timescale 1ns/10ps
`include "lcell_defines.vh"

// one configurable cell: truth table or emulated flop/latch sampled on sys_clk_i
module lcell_slice #(
  parameter IN_W = 2,
  parameter HAS_CTRL = 0
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [IN_W-1:0] in_i,
  input wire [`LCELL_CFG_W-1:0] cfg_i,
  input wire cfg_load_i,
  output reg out_o,
  output reg state_o,
  output reg capture_o
);

  localparam TRUTH_N = 1 << IN_W;

  reg clk_prev_reg;
  reg state_next;
  reg capture_next;
  wire data_w;
  wire clk_eff_w;
  wire ctrl_low_w;
  wire [TRUTH_N-1:0] truth_w;
  wire rise_w;

  assign truth_w = cfg_i[TRUTH_N-1:0];
  assign data_w = in_i[0];
  // (RULE_07) clock invert select
  assign clk_eff_w = in_i[1] ^ cfg_i[`LCELL_F_CLK_INV];
  // (RULE_08) (RULE_09) effective rising edge
  assign rise_w = clk_eff_w & ~clk_prev_reg;

  // (RULE_14) (RULE_18) third input is the control, high means inactive
  generate
    if (HAS_CTRL != 0) begin : g_ctrl
      assign ctrl_low_w = ~in_i[IN_W-1];
    end else begin : g_noctrl
      assign ctrl_low_w = 1'b0;
    end
  endgenerate

  // next stored value; config load wins, then control, then clocking
  always @* begin
    state_next = state_o;
    capture_next = 1'b0;
    if (cfg_load_i) begin
      // (RULE_13) start from initial state
      state_next = cfg_i[`LCELL_F_INIT];
    end else if (ctrl_low_w) begin
      // (RULE_19) (RULE_16) (RULE_17) override wins
      state_next = cfg_i[`LCELL_F_PRESET];
    end else if (cfg_i[`LCELL_F_LATCH]) begin
      // (RULE_10) (RULE_11) transparent while effective clock low
      if (!clk_eff_w) begin
        state_next = data_w;
        capture_next = 1'b1;
      end
    end else if (rise_w) begin
      // (RULE_06) (RULE_08) (RULE_09) edge capture
      state_next = data_w;
      capture_next = 1'b1;
    end
  end

  // storage and output flops
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_prev_reg <= 1'b0;
      state_o <= 1'b0;
      out_o <= 1'b0;
      capture_o <= 1'b0;
    end else begin
      clk_prev_reg <= clk_eff_w;
      state_o <= state_next;
      capture_o <= capture_next & cfg_i[`LCELL_F_SEQ];
      // (RULE_01) mode picked by config bit only
      if (cfg_i[`LCELL_F_SEQ]) begin
        // (RULE_12) output polarity
        out_o <= state_next ^ cfg_i[`LCELL_F_OUT_INV];
      end else begin
        // (RULE_03) (RULE_05) selected truth bit
        out_o <= truth_w[in_i];
      end
    end
  end

endmodule // lcell_slice

// ===== logic/lcell_top.v
`timescale 1ns/10ps
`include "lcell_defines.vh"

// two configurable cells behind an ahb-lite register slave
module lcell_top #(
  parameter SMALL_W = 2,
  parameter LARGE_W = 3,
  parameter CNT_W = 16
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire [SMALL_W-1:0] small_in_i,
  input wire [LARGE_W-1:0] large_in_i,
  output wire small_out_o,
  output wire large_out_o
);

  localparam PIN_W = SMALL_W + LARGE_W;

  // bus phase state
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  reg [`LCELL_CFG_W-1:0] cfg_small_reg;
  reg [`LCELL_CFG_W-1:0] cfg_large_reg;
  reg load_small_reg;
  reg load_large_reg;
  reg [CNT_W-1:0] cnt_small_reg;
  reg [CNT_W-1:0] cnt_large_reg;
  reg [31:0] rd_next;

  // pin synchronisers
  reg [PIN_W-1:0] pin_meta_reg;
  reg [PIN_W-1:0] pin_sync_reg;
  wire [PIN_W-1:0] pin_raw_w;
  wire [SMALL_W-1:0] small_sync_w;
  wire [LARGE_W-1:0] large_sync_w;

  // cell results
  wire small_state_w;
  wire large_state_w;
  wire small_cap_w;
  wire large_cap_w;

  // address phase qualifiers
  wire addr_ok_w;
  wire wr_take_w;
  wire rd_take_w;
  wire [11:0] ofs_w;

  assign pin_raw_w = {large_in_i, small_in_i};
  assign small_sync_w = pin_sync_reg[SMALL_W-1:0];
  assign large_sync_w = pin_sync_reg[PIN_W-1:SMALL_W];

  assign addr_ok_w = hsel_i & hready_i & (htrans_i == `LCELL_HTRANS_NONSEQ);
  assign wr_take_w = addr_ok_w & hwrite_i;
  assign rd_take_w = addr_ok_w & ~hwrite_i;
  assign ofs_w = haddr_i[11:0];

  // routed inputs come from another domain, two flops each
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw_w[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  // read data is selected in the address phase so it stands from a flop
  always @* begin
    rd_next = 32'h0000_0000;
    case (ofs_w)
      `LCELL_OFS_CFG_SMALL: begin
        rd_next[`LCELL_CFG_W-1:0] = cfg_small_reg;
      end
      `LCELL_OFS_CFG_LARGE: begin
        rd_next[`LCELL_CFG_W-1:0] = cfg_large_reg;
      end
      `LCELL_OFS_STATUS: begin
        rd_next[`LCELL_S_SMALL_IN +: SMALL_W] = small_sync_w;
        rd_next[`LCELL_S_LARGE_IN +: LARGE_W] = large_sync_w;
        rd_next[`LCELL_S_SMALL_OUT] = small_out_o;
        rd_next[`LCELL_S_LARGE_OUT] = large_out_o;
        rd_next[`LCELL_S_SMALL_ST] = small_state_w;
        rd_next[`LCELL_S_LARGE_ST] = large_state_w;
      end
      `LCELL_OFS_COUNT: begin
        rd_next[CNT_W-1:0] = cnt_small_reg;
        rd_next[CNT_W +: CNT_W] = cnt_large_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // ahb-lite slave: zero wait states, always okay
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= `LCELL_HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= `LCELL_HRESP_OKAY;
      wr_pend_reg <= wr_take_w;
      if (addr_ok_w) begin
        wr_addr_reg <= ofs_w;
      end
      if (rd_take_w) begin
        hrdata_o <= rd_next;
      end
    end
  end

  // configuration writes land in the data phase
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_small_reg <= `LCELL_CFG_RST;
      cfg_large_reg <= `LCELL_CFG_RST;
      load_small_reg <= 1'b1;
      load_large_reg <= 1'b1;
    end else begin
      load_small_reg <= 1'b0;
      load_large_reg <= 1'b0;
      if (wr_pend_reg && wr_addr_reg == `LCELL_OFS_CFG_SMALL) begin
        // (RULE_01) (RULE_02) small cell mode set by software
        cfg_small_reg <= hwdata_i[`LCELL_CFG_W-1:0];
        // small truth table has only four bits; upper ones read as zero
        cfg_small_reg[`LCELL_F_TRUTH_HI:4] <= 4'h0;
        // small cell has no control input
        cfg_small_reg[`LCELL_F_PRESET] <= 1'b0;
        load_small_reg <= 1'b1;
      end
      if (wr_pend_reg && wr_addr_reg == `LCELL_OFS_CFG_LARGE) begin
        // (RULE_04) (RULE_15) large cell mode and control kind
        cfg_large_reg <= hwdata_i[`LCELL_CFG_W-1:0];
        load_large_reg <= 1'b1;
      end
    end
  end

  // capture counters show the cells are actually clocking; write clears, or loads one if a capture lands in the same cycle
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_small_reg <= `LCELL_CNT_RST;
      cnt_large_reg <= `LCELL_CNT_RST;
    end else if (wr_pend_reg && wr_addr_reg == `LCELL_OFS_COUNT) begin
      cnt_small_reg <= small_cap_w ? {{(CNT_W-1){1'b0}}, 1'b1} : `LCELL_CNT_RST;
      cnt_large_reg <= large_cap_w ? {{(CNT_W-1){1'b0}}, 1'b1} : `LCELL_CNT_RST;
    end else begin
      if (small_cap_w) begin
        cnt_small_reg <= cnt_small_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (large_cap_w) begin
        cnt_large_reg <= cnt_large_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // (RULE_02) (RULE_06) two-input cell
  lcell_slice #(
    .IN_W(SMALL_W),
    .HAS_CTRL(0)
  ) u_small (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_i(small_sync_w),
    .cfg_i(cfg_small_reg),
    .cfg_load_i(load_small_reg),
    .out_o(small_out_o),
    .state_o(small_state_w),
    .capture_o(small_cap_w)
  );

  // (RULE_04) (RULE_14) three-input cell with clear or preset
  lcell_slice #(
    .IN_W(LARGE_W),
    .HAS_CTRL(1)
  ) u_large (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_i(large_sync_w),
    .cfg_i(cfg_large_reg),
    .cfg_load_i(load_large_reg),
    .out_o(large_out_o),
    .state_o(large_state_w),
    .capture_o(large_cap_w)
  );

endmodule // lcell_top

// ===== dv/lcell_fabric.sv
`timescale 1ns/10ps
// routing fabric model feeding the cell pins
module lcell_fabric (
  input wire sys_clk_i,
  input wire slow_i,
  input wire [1:0] small_req_i,
  input wire [2:0] large_req_i,
  output reg [1:0] small_pin_o,
  output reg [2:0] large_pin_o
);
  reg [4:0] stage_reg;
  // control bit passed through as requested, not forced high
  // a slow route adds one stage, so pins lag a cycle more
  always @(posedge sys_clk_i) begin
    stage_reg <= {large_req_i, small_req_i};
    {large_pin_o, small_pin_o} <= slow_i ? stage_reg : {large_req_i, small_req_i};
  end
endmodule // lcell_fabric

// ===== dv/lcell_checker.sv
`timescale 1ns/10ps
// port-level checks on the bus and both cell outputs
module lcell_checker (
  input wire sys_clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire [1:0] small_in_i,
  input wire [2:0] large_in_i,
  input wire small_out_o,
  input wire large_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // taken transfers; writes may reload a cell, so holds exclude them
  wire tk = hsel_i && hready_i && htrans_i == 2'h2;
  wire rd = tk && !hwrite_i;
  wire wr = tk && hwrite_i;
  wire [11:0] a = haddr_i[11:0];
  a_ready_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not ready");
  a_reset_clears: assert property (disable iff (1'b0)
    rst_i |=> !small_out_o && !large_out_o && hrdata_o == 32'h0) else $error("reset value");
  a_small_hold: assert property (
    (!wr && $stable(small_in_i))[*4] |=> $stable(small_out_o)) else $error("small moved");
  a_large_hold: assert property (
    (!wr && $stable(large_in_i))[*4] |=> $stable(large_out_o)) else $error("large moved");
  a_small_cfg_rd: assert property (rd && a == 12'h000 |=>
    hrdata_o[31:13] == 19'h0 && hrdata_o[7:4] == 4'h0) else $error("small cfg bits");
  a_large_cfg_rd: assert property (rd && a == 12'h004 |=>
    hrdata_o[31:14] == 18'h0) else $error("large cfg bits");
  a_unmapped_zero: assert property (rd && a > 12'h00c |=> hrdata_o == 32'h0)
    else $error("unmapped read");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata_o)) else $error("read data moved");
endmodule // lcell_checker
bind lcell_top lcell_checker u_chk (.*);

// ===== dv/tb_lcell_top.sv
`timescale 1ns/10ps
module tb_lcell_top;
  reg sys_clk_i = 0;
  reg rst_i = 1;
  reg hsel = 0;
  reg hwrite = 0;
  reg slow = 0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [1:0] sreq = 2'h0;
  reg [2:0] lreq = 3'h4; // control idles high
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire hrdy;
  wire sout;
  wire lout;
  wire [1:0] spin;
  wire [2:0] lpin;
  integer fail_count = 0;
  integer checked = 0;
  integer i;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  lcell_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
    .small_in_i(spin), .large_in_i(lpin), .small_out_o(sout), .large_out_o(lout));
  lcell_fabric u_fab (.sys_clk_i(sys_clk_i), .slow_i(slow), .small_req_i(sreq),
    .large_req_i(lreq), .small_pin_o(spin), .large_pin_o(lpin));
  task print_verdict;
    begin
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  // bounded wait for hready at an edge; a hang ends the run
  task wt;
    integer n;
    begin
      n = 0;
      @(posedge sys_clk_i);
      while (hrdy !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge sys_clk_i);
      end
      if (n == 50) begin
        fail_count = fail_count + 1;
        print_verdict;
      end
    end
  endtask
  // one single transfer; read data taken at the data phase's end edge
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge sys_clk_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      rd = hrdata;
    end
  endtask
  // pin steps; six cycles cover fabric lag plus the three-cycle pin-to-out path
  task ss(input [1:0] s, input e);
    begin
      @(posedge sys_clk_i);
      sreq <= s;
      repeat (6) @(posedge sys_clk_i);
      cmp({31'h0, e}, {31'h0, sout});
    end
  endtask
  task ls(input [2:0] l, input e);
    begin
      @(posedge sys_clk_i);
      lreq <= l;
      repeat (6) @(posedge sys_clk_i);
      cmp({31'h0, e}, {31'h0, lout});
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // reset values, then reserved bits and an unmapped write
    // status shows the synced large pins, whose control bit idles high
    for (i = 0; i < 20; i = i + 4) begin
      bus(0, i, 0);
      cmp((i == 8) ? {25'h0, lreq, 4'h0} : 32'h0, rd);
    end
    bus(1, 32'h0, 32'hffffffff);
    bus(1, 32'h4, 32'hffffffff);
    bus(1, 32'h10, 32'hffffffff);
    bus(0, 32'h0, 0);
    cmp(32'h1f0f, rd);
    bus(0, 32'h4, 0);
    cmp(32'h3fff, rd);
    bus(0, 32'h10, 0);
    cmp(32'h0, rd);
    // every input combination selects its truth bit
    bus(1, 32'h0, 32'h6);
    bus(1, 32'h4, 32'h96);
    for (i = 0; i < 4; i = i + 1) ss(i, (6 >> i) & 1);
    slow <= 1'b1;
    for (i = 0; i < 8; i = i + 1) ls(i, (8'h96 >> i) & 1);
    slow <= 1'b0;
    // small cell as flop, inverted flop, inverted latch, plain latch
    bus(1, 32'h0, 32'h100);
    bus(1, 32'hc, 32'h0);
    ss(2'h1, 0);
    ss(2'h3, 1);
    ss(2'h2, 1);
    ss(2'h0, 1);
    // only the one rising clock edge may count as a small capture
    bus(0, 32'hc, 0);
    cmp(32'h1, rd);
    bus(1, 32'h0, 32'h500);
    ss(2'h3, 0);
    ss(2'h1, 1);
    bus(1, 32'h0, 32'h700);
    ss(2'h0, 0);
    ss(2'h3, 1);
    ss(2'h2, 0);
    ss(2'h0, 0);
    ss(2'h1, 0);
    ss(2'h2, 0);
    bus(1, 32'h0, 32'h1b00);
    ss(2'h2, 0);
    ss(2'h0, 1);
    ss(2'h2, 1);
    ss(2'h3, 1);
    // large cell flop with preset, then flop with clear, then latch with clear
    bus(1, 32'h4, 32'h2100);
    ls(3'h5, 0);
    ls(3'h1, 1);
    ls(3'h4, 1);
    ls(3'h6, 0);
    bus(1, 32'h4, 32'h100);
    ls(3'h5, 0);
    ls(3'h7, 1);
    ls(3'h3, 0);
    ls(3'h1, 0);
    ls(3'h3, 0);
    bus(1, 32'h4, 32'h300);
    ls(3'h5, 1);
    ls(3'h1, 0);
    // back to table mode, clear counts, check synced pins
    bus(1, 32'h0, 32'h0);
    bus(1, 32'h4, 32'h0);
    bus(1, 32'hc, 32'h0);
    bus(0, 32'hc, 0);
    cmp(32'h0, rd);
    bus(0, 32'h8, 0);
    cmp({25'h0, lreq, 2'h0, sreq}, rd & 32'hf73);
    print_verdict;
  end
endmodule // tb_lcell_top
